// ### design/irq_vector_ctrl.sv
// Interrupt level registers, priority resolution and vector addressing
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------------
// Summary of operation
// - Each vector is two bytes, upper byte even address, lower byte next odd.
// - Vectors step down two bytes per request number, 0 at top, 23 lowest.
// - Every request number has its own two-bit level field, same index.
// - Among equal-level pending requests the lowest request number wins.
// - External channel 4 raises request 0, channel 6 raises request 2.
// - Composite timer 0 lower half raises 5, upper half raises 6.
// - A/D raises 18, time-base timer 19, watch prescaler 20.
// - Flash controller raises 23, the last position among equal levels.
// - Requests 1,3,4,7-17,21,22 have no source but keep vector and level.
// - Level fields pack four per byte in six registers reset to ones.
// ------------------------------------------------------------------
module irq_vector_ctrl (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic ext_int4,
  input wire logic ext_int6,
  input wire logic ct0_lower,
  input wire logic ct0_upper,
  input wire logic adc_done,
  input wire logic timebase_tick,
  input wire logic watch_tick,
  input wire logic flash_done,
  input wire logic [1:0] cpu_level,
  output logic irq,
  output logic cpu_irq_req,
  output logic [4:0] cpu_irq_num,
  output logic [1:0] cpu_irq_level,
  output logic [15:0] vec_upper_addr,
  output logic [15:0] vec_lower_addr
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [47:0] levels;
    logic [23:0] status;
    logic [23:0] mask;
    logic [23:0] src_prev;
    logic irq;
    logic cpu_req;
    logic [4:0] num;
    logic [1:0] lvl;
    logic [15:0] vec_hi;
    logic [15:0] vec_lo;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } state_t;

  // Levels reset to all ones: level 3 can never beat any CPU level
  localparam state_t STATE_RESET = '{
    levels: {6{irq_vec_pkg::LVL_REG_RESET}},
    default: '0
  };

  state_t s_q;
  state_t s_d;

  logic [23:0] req;
  logic [23:0] rise;
  logic [23:0] elig;
  logic win_valid;
  logic [4:0] win_num;
  logic [1:0] win_lvl;
  logic [9:0] idx;
  logic lvl_hit;
  logic [2:0] lvl_sel;
  logic apb_done;
  logic apb_wait;

  // ----------------------------------------------------------------
  // Source routing and priority resolution
  // ----------------------------------------------------------------
  irq_source_map u_map (
    .ext_int4(ext_int4),
    .ext_int6(ext_int6),
    .ct0_lower(ct0_lower),
    .ct0_upper(ct0_upper),
    .adc_done(adc_done),
    .timebase_tick(timebase_tick),
    .watch_tick(watch_tick),
    .flash_done(flash_done),
    .req(req)
  );

  // Mask gates both the CPU request path and the summary output
  assign elig = req & s_q.mask;

  irq_level_arbiter #(
    .N(irq_vec_pkg::NUM_REQ)
  ) u_arb (
    .elig(elig),
    .levels(s_q.levels),
    .win_valid(win_valid),
    .win_num(win_num),
    .win_lvl(win_lvl)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // One wait state: pready rises in the second access cycle
  assign apb_wait = psel && penable && !s_q.pready;
  assign apb_done = psel && penable && s_q.pready;
  assign idx = paddr[11:2];
  assign lvl_hit = (paddr[1:0] == 2'h0) &&
                   (idx >= irq_vec_pkg::LVL_REG0_IDX) &&
                   (idx <= irq_vec_pkg::LVL_REG5_IDX);
  assign lvl_sel = 3'(idx - irq_vec_pkg::LVL_REG0_IDX);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    rise = req & ~s_q.src_prev;
    s_d.src_prev = req;

    // Register writes take effect at the completing edge only
    if (apb_done && pwrite) begin
      if (lvl_hit && pstrb[0]) begin
        s_d.levels[8*lvl_sel +: 8] = pwdata[7:0];
      end
      if (paddr == irq_vec_pkg::MASK_ADDR) begin
        for (int b = 0; b < 3; b++) begin
          if (pstrb[b]) begin
            s_d.mask[8*b +: 8] = pwdata[8*b +: 8];
          end
        end
      end
    end

    // Read of status clears only the bits it reported; prdata still holds
    // that snapshot, so an edge landing after the snapshot is not lost
    if (apb_done && !pwrite && paddr == irq_vec_pkg::STATUS_ADDR) begin
      s_d.status = s_q.status & ~s_q.prdata[23:0];
    end
    s_d.status = s_d.status | rise;

    // Answer phase: data and error loaded with pready
    s_d.pready = apb_wait;
    s_d.prdata = 32'h00000000;
    s_d.pslverr = 1'b0;
    if (apb_wait) begin
      if (lvl_hit) begin
        s_d.prdata[7:0] = s_q.levels[8*lvl_sel +: 8];
      end else begin
        case (paddr)
          irq_vec_pkg::STATUS_ADDR: begin
            s_d.prdata[23:0] = s_q.status;
          end
          irq_vec_pkg::MASK_ADDR: begin
            s_d.prdata[23:0] = s_q.mask;
          end
          irq_vec_pkg::CPU_VIEW_ADDR: begin
            s_d.prdata[irq_vec_pkg::VIEW_NUM_LSB +: 5] = s_q.num;
            s_d.prdata[irq_vec_pkg::VIEW_LVL_LSB +: 2] = s_q.lvl;
            s_d.prdata[irq_vec_pkg::VIEW_REQ_BIT] = s_q.cpu_req;
          end
          default: begin
            s_d.pslverr = 1'b1;
          end
        endcase
      end
    end

    // Only a request more urgent than the CPU is offered
    s_d.cpu_req = win_valid && (win_lvl < cpu_level);
    if (s_d.cpu_req) begin
      s_d.num = win_num;
      s_d.lvl = win_lvl;
      s_d.vec_hi = irq_vec_pkg::VEC_TOP - {10'h000, win_num, 1'b0};
      s_d.vec_lo = s_d.vec_hi | 16'h0001;
    end

    s_d.irq = |(s_d.status & s_d.mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign pready = s_q.pready;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;
  assign irq = s_q.irq;
  assign cpu_irq_req = s_q.cpu_req;
  assign cpu_irq_num = s_q.num;
  assign cpu_irq_level = s_q.lvl;
  assign vec_upper_addr = s_q.vec_hi;
  assign vec_lower_addr = s_q.vec_lo;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Helper: some eligible request beats the chosen one
  logic hp_viol;
  always_comb begin
    hp_viol = 1'b0;
    for (int i = 0; i < irq_vec_pkg::NUM_REQ; i++) begin
      if (elig[i] && win_valid &&
          (s_q.levels[2*i +: 2] < win_lvl ||
           (s_q.levels[2*i +: 2] == win_lvl && 5'(i) < win_num))) begin
        hp_viol = 1'b1;
      end
    end
  end

  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_complete;
    psel && penable && pready;
  endsequence

  a_vec_byte_pair:
    assert property (cpu_irq_req |-> !vec_upper_addr[0] &&
                     vec_lower_addr == vec_upper_addr + 16'h0001)
    else $error("vector lower byte not at next odd address");

  a_vec_step_down:
    assert property (cpu_irq_req |-> vec_upper_addr ==
                     irq_vec_pkg::VEC_TOP - {10'h000, cpu_irq_num, 1'b0})
    else $error("vector address does not step by two");

  a_level_field_own:
    assert property (cpu_irq_req |->
                     cpu_irq_level == $past(s_q.levels[{win_num, 1'b0} +: 2]))
    else $error("level does not come from the request field");

  a_tie_lowest_num:
    assert property (!hp_viol)
    else $error("a more urgent or lower numbered request was passed over");

  a_ext_map:
    assert property ($rose(ext_int4) or $rose(ext_int6) |=>
                     (s_q.status[0] || !$past(ext_int4)) &&
                     (s_q.status[2] || !$past(ext_int6)))
    else $error("external channel did not set its request");

  a_timer_map:
    assert property ($rose(ct0_lower) |=> s_q.status[5] ##0
                     ($past(ct0_upper, 2) || !$past(ct0_upper) ||
                      s_q.status[6]))
    else $error("composite timer did not set its request");

  a_misc_map:
    assert property ($rose(adc_done) ##0 $rose(timebase_tick) ##0
                     $rose(watch_tick) |=> s_q.status[20:18] == 3'h7)
    else $error("converter or timer request not raised");

  a_flash_last:
    assert property ($rose(flash_done) |=> s_q.status[23])
    else $error("flash did not set request 23");

  a_unused_quiet:
    assert property ((s_q.status & ~irq_vec_pkg::USED_REQS) == 24'h000000)
    else $error("request without a source became pending");

  a_level_reset:
    assert property ($fell(rst) |-> s_q.levels == {48{1'b1}})
    else $error("level registers not all ones after reset");

  a_accept_urgent:
    assert property (cpu_irq_req |-> cpu_irq_level < $past(cpu_level))
    else $error("request offered that is not more urgent than the CPU");

  a_apb_one_wait:
    assert property (s_access |=> s_complete ##1 !pready)
    else $error("APB answer not after exactly one wait state");

  // ----------------------------------------------------------------
  // Register bus and status checks
  // ----------------------------------------------------------------
  // Decode kept apart from the answer logic so a decode slip shows up
  logic addr_mapped;
  assign addr_mapped = lvl_hit ||
                       paddr == irq_vec_pkg::STATUS_ADDR ||
                       paddr == irq_vec_pkg::MASK_ADDR ||
                       paddr == irq_vec_pkg::CPU_VIEW_ADDR;

  // Completing edge of a status read
  logic status_rd;
  assign status_rd = apb_done && !pwrite && paddr == irq_vec_pkg::STATUS_ADDR;

  sequence s_status_read;
    psel && penable && !pready && !pwrite && paddr == irq_vec_pkg::STATUS_ADDR ##1 status_rd;
  endsequence

  a_status_sticky:
    assert property (!status_rd |=> (s_q.status & $past(s_q.status)) == $past(s_q.status))
    else $error("status bit cleared without a status read");

  a_read_clears:
    assert property (s_status_read |=> (s_q.status & $past(prdata[23:0] & ~rise)) == 24'h000000)
    else $error("reported status bit survived its read");

  a_unmapped_err:
    assert property (psel && penable && !pready && !addr_mapped |=>
                     pslverr && prdata == 32'h00000000)
    else $error("unmapped address answered without an error");

  a_idle_quiet:
    assert property (!pready |-> prdata == 32'h00000000 && !pslverr)
    else $error("read data or error outside the answer cycle");

  a_level_write:
    assert property (apb_done && pwrite && lvl_hit && pstrb[0] |=>
                     s_q.levels[8*$past(lvl_sel) +: 8] == $past(pwdata[7:0]))
    else $error("level register write did not land");

  a_vec_hold:
    assert property (!cpu_irq_req |-> $stable(cpu_irq_num) && $stable(vec_upper_addr) &&
                     $stable(vec_lower_addr))
    else $error("vector changed while no request was offered");

  a_mask_gates:
    assert property (cpu_irq_req |-> $past(req[win_num] && s_q.mask[win_num]))
    else $error("request offered from a masked or idle source");
endmodule : irq_vector_ctrl
`default_nettype wire

// ### inc/irq_vec_pkg.sv
// Shared constants for the interrupt level and vector controller
`default_nettype none
package irq_vec_pkg;
  // ----------------------------------------------------------------
  // Request numbering and level fields
  // ----------------------------------------------------------------
  localparam int NUM_REQ = 24;
  localparam int LVL_W = 2;
  localparam int NUM_LVL_REGS = 6;
  localparam int FIELDS_PER_REG = 4;
  localparam logic [7:0] LVL_REG_RESET = 8'hff;
  localparam logic [4:0] REQ_EXT4 = 5'h00;
  localparam logic [4:0] REQ_EXT6 = 5'h02;
  localparam logic [4:0] REQ_CT0_LO = 5'h05;
  localparam logic [4:0] REQ_CT0_HI = 5'h06;
  localparam logic [4:0] REQ_ADC = 5'h12;
  localparam logic [4:0] REQ_TBT = 5'h13;
  localparam logic [4:0] REQ_WPRE = 5'h14;
  localparam logic [4:0] REQ_FLASH = 5'h17;
  // Requests that have a source wired in this variant
  localparam logic [23:0] USED_REQS = 24'h9c0065;

  // ----------------------------------------------------------------
  // Vector table
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_TOP = 16'hfffa;

  // ----------------------------------------------------------------
  // APB map (level registers by index, byte address = 4 x index)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [9:0] LVL_REG0_IDX = 10'h079;
  localparam logic [9:0] LVL_REG5_IDX = 10'h07e;
  localparam logic [11:0] STATUS_ADDR = 12'h200;
  localparam logic [11:0] MASK_ADDR = 12'h204;
  localparam logic [11:0] CPU_VIEW_ADDR = 12'h208;
  // Fields of the CPU view register
  localparam int VIEW_NUM_LSB = 0;
  localparam int VIEW_LVL_LSB = 8;
  localparam int VIEW_REQ_BIT = 16;
endpackage : irq_vec_pkg
`default_nettype wire

// ### design/irq_source_map.sv
// Routing of peripheral interrupt lines onto request numbers
`timescale 1ns/10ps
`default_nettype none
module irq_source_map (
  input wire logic ext_int4,
  input wire logic ext_int6,
  input wire logic ct0_lower,
  input wire logic ct0_upper,
  input wire logic adc_done,
  input wire logic timebase_tick,
  input wire logic watch_tick,
  input wire logic flash_done,
  output logic [23:0] req
);
  // ----------------------------------------------------------------
  // Fixed wiring; slots without a source stay quiet
  // ----------------------------------------------------------------
  always_comb begin
    req = 24'h000000;
    req[irq_vec_pkg::REQ_EXT4] = ext_int4;
    req[irq_vec_pkg::REQ_EXT6] = ext_int6;
    req[irq_vec_pkg::REQ_CT0_LO] = ct0_lower;
    req[irq_vec_pkg::REQ_CT0_HI] = ct0_upper;
    req[irq_vec_pkg::REQ_ADC] = adc_done;
    req[irq_vec_pkg::REQ_TBT] = timebase_tick;
    req[irq_vec_pkg::REQ_WPRE] = watch_tick;
    req[irq_vec_pkg::REQ_FLASH] = flash_done;
  end
endmodule : irq_source_map
`default_nettype wire

// ### design/irq_level_arbiter.sv
// Picks the most urgent eligible request, lowest number on ties
`timescale 1ns/10ps
`default_nettype none
module irq_level_arbiter #(
  parameter int N = 24
) (
  input wire logic [N-1:0] elig,
  input wire logic [2*N-1:0] levels,
  output logic win_valid,
  output logic [4:0] win_num,
  output logic [1:0] win_lvl
);
  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (N < 1 || N > 32) begin : g_bad_n
    $error("irq_level_arbiter: N must be 1 to 32");
  end

  // ----------------------------------------------------------------
  // Per-request level fields
  // ----------------------------------------------------------------
  logic [1:0] lvl_a [N];
  for (genvar i = 0; i < N; i++) begin : g_lvl
    assign lvl_a[i] = levels[2*i +: 2];
  end

  // Scan from the top down with <= so the lower number wins a tie
  always_comb begin
    win_valid = 1'b0;
    win_num = 5'h00;
    win_lvl = 2'h3;
    for (int i = N - 1; i >= 0; i--) begin
      if (elig[i] && (!win_valid || lvl_a[i] <= win_lvl)) begin
        win_valid = 1'b1;
        win_num = 5'(i);
        win_lvl = lvl_a[i];
      end
    end
  end
endmodule : irq_level_arbiter
`default_nettype wire

// ### sim/cpu_core_model.sv
// Behavioural CPU core that takes requests and fetches their vectors
`timescale 1ns/10ps
`default_nettype none
module cpu_core_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] run_level,
  input wire logic cpu_irq_req,
  input wire logic [15:0] vec_upper_addr,
  input wire logic [15:0] vec_lower_addr,
  output logic [1:0] cpu_level,
  output logic [15:0] fetch_hi,
  output logic [15:0] fetch_lo
);
  // Level follows the running program; fetch both bytes while a request stands
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cpu_level <= 2'h3;
      fetch_hi <= 16'h0000;
      fetch_lo <= 16'h0000;
    end else begin
      cpu_level <= run_level;
      if (cpu_irq_req) begin
        fetch_hi <= vec_upper_addr;
        fetch_lo <= vec_lower_addr;
      end
    end
  end
endmodule : cpu_core_model
`default_nettype wire

// ### sim/interrupt_vector_priority_bench.sv
// Self-checking bench for the interrupt level and vector controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin n_fail++; $display("BAD %s exp %h got %h", nm, ex, gt); end end
module interrupt_vector_priority_bench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, irq, cpu_irq_req, er;
  logic [31:0] prdata, rd;
  logic [7:0] src = 8'h00;
  logic [1:0] run_level = 2'h3;
  logic [1:0] cpu_level, cpu_irq_level;
  logic [4:0] cpu_irq_num;
  logic [15:0] vec_u, vec_l, fetch_hi, fetch_lo;
  int n_fail = 0;
  int samples_checked = 0;
  // Request number of each source line, in port order
  logic [4:0] num_of [8] = '{5'h00, 5'h02, 5'h05, 5'h06, 5'h12, 5'h13, 5'h14, 5'h17};

  always #5 clock = ~clock;

  irq_vector_ctrl dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_int4(src[0]), .ext_int6(src[1]), .ct0_lower(src[2]), .ct0_upper(src[3]), .adc_done(src[4]),
    .timebase_tick(src[5]), .watch_tick(src[6]), .flash_done(src[7]), .cpu_level(cpu_level), .irq(irq),
    .cpu_irq_req(cpu_irq_req), .cpu_irq_num(cpu_irq_num), .cpu_irq_level(cpu_irq_level),
    .vec_upper_addr(vec_u), .vec_lower_addr(vec_l));

  cpu_core_model cpu (.clock(clock), .rst(rst), .run_level(run_level), .cpu_irq_req(cpu_irq_req),
    .vec_upper_addr(vec_u), .vec_lower_addr(vec_l), .cpu_level(cpu_level), .fetch_hi(fetch_hi),
    .fetch_lo(fetch_lo));

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  // One APB transfer; a dead slave is left to the watchdog
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] ex, input logic exerr);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", ex, rd)
    `CHK("pslverr", exerr, er)
  endtask : rdchk

  task automatic settle(input logic [7:0] s);
    @(posedge clock);
    src <= s;
    repeat (3) @(posedge clock);
  endtask : settle

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    for (int k = 0; k < 6; k++) rdchk(12'h1e4 + 12'(4 * k), 32'h0000_00ff, 1'b0);
    rdchk(irq_vec_pkg::MASK_ADDR, 32'h0, 1'b0);
    rdchk(12'h100, 32'h0, 1'b1);
    $display("reset values done");
    // Distinct value per field; upper write bits must not stick
    for (int k = 0; k < 6; k++) apb(1'b1, 12'h1e4 + 12'(4 * k), 32'hffff_ff1b);
    for (int k = 0; k < 6; k++) rdchk(12'h1e4 + 12'(4 * k), 32'h0000_001b, 1'b0);
    $display("level fields done");
    apb(1'b1, irq_vec_pkg::MASK_ADDR, 32'h00ff_ffff);
    for (int k = 0; k < 6; k++) apb(1'b1, 12'h1e4 + 12'(4 * k), 32'h0);
    for (int i = 0; i < 8; i++) begin
      settle(8'(1 << i));
      `CHK("req", 1'b1, cpu_irq_req)
      `CHK("num", num_of[i], cpu_irq_num)
      `CHK("vec_hi", 16'hfffa - {10'h0, num_of[i], 1'b0}, fetch_hi)
      `CHK("vec_lo", 16'hfffb - {10'h0, num_of[i], 1'b0}, fetch_lo)
      settle(8'h00);
      `CHK("req_off", 1'b0, cpu_irq_req)
    end
    $display("source routing done");
    settle(8'hff);
    `CHK("tie_num", 5'h00, cpu_irq_num)
    apb(1'b1, 12'h1e4, 32'h0000_0002);
    repeat (3) @(posedge clock);
    `CHK("lvl_num", 5'h02, cpu_irq_num)
    `CHK("lvl_val", 2'h0, cpu_irq_level)
    rdchk(irq_vec_pkg::CPU_VIEW_ADDR,
      (32'h1 << irq_vec_pkg::VIEW_REQ_BIT) | (32'h2 << irq_vec_pkg::VIEW_NUM_LSB), 1'b0);
    run_level <= 2'h0;
    repeat (3) @(posedge clock);
    `CHK("refuse", 1'b0, cpu_irq_req)
    $display("priority done");
    apb(1'b0, irq_vec_pkg::STATUS_ADDR, 32'h0);
    settle(8'h00);
    settle(8'hff);
    `CHK("irq_on", 1'b1, irq)
    rdchk(irq_vec_pkg::STATUS_ADDR, 32'h009c_0065, 1'b0);
    rdchk(irq_vec_pkg::STATUS_ADDR, 32'h0, 1'b0);
    repeat (2) @(posedge clock);
    `CHK("irq_clr", 1'b0, irq)
    apb(1'b1, irq_vec_pkg::MASK_ADDR, 32'h0);
    settle(8'h00);
    settle(8'h01);
    `CHK("irq_mask", 1'b0, irq)
    apb(1'b1, irq_vec_pkg::MASK_ADDR, 32'h1);
    repeat (2) @(posedge clock);
    `CHK("irq_unmask", 1'b1, irq)
    $display("interrupt done");
    finish_test();
  end

  // Watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    finish_test();
  end
endmodule : interrupt_vector_priority_bench
`default_nettype wire
